// ### src/acr_pkg.sv
// acr_pkg: constants, field layouts and carrier types of the codec control register bank.
// assumes one 25 MHz system clock; shared by acr_regs and acr_chan.
package acr_pkg;

  // register offsets on the control port
  localparam logic [7:0] ADDR_ADC_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_DAC_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_LEFT_OUTPUT_VOLUME = 8'h03;
  localparam logic [7:0] ADDR_RIGHT_OUTPUT_VOLUME = 8'h04;
  localparam logic [7:0] ADDR_SERIAL_PORT_FORMAT = 8'h05;
  localparam logic [7:0] ADDR_CONVERTER_STATUS = 8'h06;
  localparam logic [7:0] ADDR_MASTER_CLOCK_RATIO = 8'h07;

  localparam logic [7:0] REG_RESET = 8'h00;

  // writable bits; the rest are reserved or read-only
  localparam logic [7:0] ADC_WMASK = 8'hfc;
  localparam logic [7:0] DAC_WMASK = 8'h7b;
  localparam logic [7:0] VOL_WMASK = 8'hff;
  localparam logic [7:0] SPF_WMASK = 8'h7f;
  localparam logic [7:0] MCK_WMASK = 8'h03;

  // adc_control fields
  localparam int ADC_SLEEP_BIT = 7;
  localparam int HP_BYPASS_R_BIT = 6;
  localparam int HP_BYPASS_L_BIT = 5;
  localparam int ADC_SILENCE_R_BIT = 4;
  localparam int ADC_SILENCE_L_BIT = 3;
  localparam int CAL_ON_RESET_BIT = 2;
  // dac_control fields
  localparam int ZERO_RUN_EN_BIT = 6;
  localparam int DAC_SILENCE_R_BIT = 5;
  localparam int DAC_SILENCE_L_BIT = 4;
  localparam int ZERO_CROSS_MODE_BIT = 3;
  localparam int RAMP_RATE_LSB = 0;
  // serial_port_format and master_clock_ratio fields
  localparam int TREBLE_CUT_LSB = 5;
  localparam int EDGE_SELECT_BIT = 4;
  localparam int OUT_LAYOUT_LSB = 2;
  localparam int IN_LAYOUT_LSB = 0;
  localparam int MCLK_RATIO_LSB = 0;

  // timing
  localparam longint CLK_HZ = 25_000_000;
  localparam longint CAL_TIME_MS = 50;
  localparam longint CAL_CYCLES = CLK_HZ / 1000 * CAL_TIME_MS;
  localparam int CLK_FAULT_CYCLES = 2048;
  localparam int ZERO_RUN_LEN = 512;
  localparam int ZERO_CROSS_TIMEOUT = 512;

  // volume coding
  localparam logic [7:0] VOL_MUTE_LIMIT = 8'he3;
  localparam logic [7:0] VOL_MUTE_CODE = 8'he4;

  localparam int SAMPLE_W = 24;

  typedef enum logic [1:0] {ACR_FMT_I2S, ACR_FMT_LEFT_JUST, ACR_FMT_RIGHT_24,
                            ACR_FMT_RIGHT_20} acr_fmt_t;
  typedef enum logic [1:0] {ACR_DEEMPH_44K1, ACR_DEEMPH_48K, ACR_DEEMPH_32K,
                            ACR_DEEMPH_OFF} acr_deemph_t;
  typedef enum logic [1:0] {ACR_MCLK_256FS, ACR_MCLK_384FS, ACR_MCLK_512FS,
                            ACR_MCLK_RSVD} acr_mclk_t;

  typedef struct packed {
    logic adc_sleep;
    logic highpass_bypass_right;
    logic highpass_bypass_left;
    logic adc_silence_right;
    logic adc_silence_left;
    acr_deemph_t treble_cut_filter_select;
    logic bit_clock_edge_select;
    acr_fmt_t serial_output_layout;
    acr_fmt_t serial_input_layout;
    acr_mclk_t master_clock_ratio_select;
  } acr_cfg_t;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } acr_samp_t;

endpackage

// ### src/acr_chan.sv
// acr_chan: one dac channel's level tracker, zero-run detector and change-pending flag.
// assumes step and frame ticks are one-cycle pulses on clk_sys_in.
`timescale 1ns/10ps
module acr_chan #(
  parameter int ZR_LEN = acr_pkg::ZERO_RUN_LEN,
  parameter int ZC_TIMEOUT = acr_pkg::ZERO_CROSS_TIMEOUT
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [7:0] vol_code_in,
  input wire logic vol_write_in,
  input wire logic force_mute_in,
  input wire logic zero_run_enable_in,
  input wire logic zero_cross_mode_in,
  input wire logic step_tick_in,
  input wire logic frame_tick_in,
  input wire acr_pkg::acr_samp_t samp_in,
  output logic [7:0] level_out,
  output logic pending_out
);
  logic [9:0] zrun, next_zrun;
  logic [9:0] zc_cnt, next_zc_cnt;
  logic prev_sign, next_prev_sign;
  logic [7:0] next_level;
  logic next_pending;
  logic samp_static, crossing, run_muted;
  logic [7:0] target;

  always_comb begin
    samp_static = (samp_in.data == '0) || (&samp_in.data);
    crossing = samp_in.valid && ((samp_in.data[acr_pkg::SAMPLE_W-1] != prev_sign) ||
                                 (samp_in.data == '0));
    run_muted = zero_run_enable_in && (zrun == 10'(ZR_LEN));
    if (force_mute_in || run_muted || (vol_code_in > acr_pkg::VOL_MUTE_LIMIT)) begin
      target = acr_pkg::VOL_MUTE_CODE;
    end else begin
      target = vol_code_in;
    end
    next_zrun = zrun;
    next_prev_sign = prev_sign;
    if (samp_in.valid) begin
      next_prev_sign = samp_in.data[acr_pkg::SAMPLE_W-1];
      if (!samp_static) begin
        next_zrun = '0;
      end else if (zrun != 10'(ZR_LEN)) begin
        next_zrun = zrun + 10'd1;
      end
    end
    next_zc_cnt = zc_cnt;
    if (level_out == target) begin
      next_zc_cnt = '0;
    end else if (frame_tick_in && zc_cnt != 10'(ZC_TIMEOUT)) begin
      next_zc_cnt = zc_cnt + 10'd1;
    end
    next_level = level_out;
    if (level_out != target) begin
      if (zero_cross_mode_in) begin
        // jump in one step at a crossing, or after the timeout
        if (crossing || zc_cnt == 10'(ZC_TIMEOUT)) begin
          next_level = target;
        end
      end else if (step_tick_in) begin
        next_level = (level_out < target) ? level_out + 8'd1 : level_out - 8'd1;
      end
    end
    // a new write wins over the clear
    if (vol_write_in) begin
      next_pending = 1'b1;
    end else if (level_out == target) begin
      next_pending = 1'b0;
    end else begin
      next_pending = pending_out;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      zrun <= '0;
      zc_cnt <= '0;
      prev_sign <= 1'b0;
      level_out <= 8'h00;
      pending_out <= 1'b0;
    end else begin
      zrun <= next_zrun;
      zc_cnt <= next_zc_cnt;
      prev_sign <= next_prev_sign;
      level_out <= next_level;
      pending_out <= next_pending;
    end
  end
endmodule

// ### src/acr_regs.sv
// acr_regs: control and status register bank of the stereo codec.
// assumes the control port decoder (i2c or spi) delivers byte reads and writes on clk_sys_in;
// pins spi_mode, frame clock and codec reset line come from outside and are synchronised here.
`timescale 1ns/10ps
module acr_regs #(
  parameter longint CAL_CYCLES = acr_pkg::CAL_CYCLES,
  parameter int CLK_FAULT_CYCLES = acr_pkg::CLK_FAULT_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic reset_line_n_in,
  input wire logic spi_mode_in,
  input wire logic frame_clock_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire acr_pkg::acr_samp_t left_samp_in,
  input wire acr_pkg::acr_samp_t right_samp_in,
  input wire logic [2:0] peak_meter_left_in,
  input wire logic [2:0] peak_meter_right_in,
  input wire logic peak_valid_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output acr_pkg::acr_cfg_t cfg_out,
  output logic [7:0] left_level_out,
  output logic [7:0] right_level_out,
  output logic offset_trim_running_out,
  output logic clock_fault_flag_out
);
  localparam int CAL_W = $clog2(CAL_CYCLES + 1);
  localparam int FLT_W = $clog2(CLK_FAULT_CYCLES + 1);

  // larger code means a louder peak, so the sticky value keeps the maximum
  function automatic logic [2:0] peak_max(input logic [2:0] a, input logic [2:0] b);
    peak_max = (a > b) ? a : b;
  endfunction

  function automatic logic [5:0] step_div(input logic [1:0] rate);
    case (rate)
      2'b00: step_div = 6'h08;
      2'b01: step_div = 6'h04;
      2'b10: step_div = 6'h10;
      default: step_div = 6'h20;
    endcase
  endfunction

  function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] wd,
                                        input logic [7:0] mask);
    masked = (wd & mask) | (old & ~mask);
  endfunction

  // ---- pin synchronisers: stage 1 feeds only stage 2
  logic [2:0] sync1, sync2, next_sync1, next_sync2;
  logic frame_d, rstl_d, next_frame_d, next_rstl_d;
  logic spi_mode, frame_rise, frame_edge, rstl_rise;

  always_comb begin
    next_sync1 = {spi_mode_in, frame_clock_in, reset_line_n_in};
    next_sync2 = sync1;
    next_frame_d = sync2[1];
    next_rstl_d = sync2[0];
    spi_mode = sync2[2];
    frame_rise = sync2[1] && !frame_d;
    frame_edge = sync2[1] != frame_d;
    rstl_rise = sync2[0] && !rstl_d;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sync1 <= 3'h1;
      sync2 <= 3'h1;
      frame_d <= 1'b0;
      rstl_d <= 1'b1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      frame_d <= next_frame_d;
      rstl_d <= next_rstl_d;
    end
  end

  // ---- registers
  logic [7:0] adc_control, dac_control, left_output_volume, right_output_volume;
  logic [7:0] serial_port_format, master_clock_ratio;
  logic [7:0] next_adc_control, next_dac_control, next_left_output_volume;
  logic [7:0] next_right_output_volume, next_serial_port_format, next_master_clock_ratio;
  logic wr_left_vol, wr_right_vol;

  // writes are taken in both control port modes
  always_comb begin
    next_adc_control = adc_control;
    next_dac_control = dac_control;
    next_left_output_volume = left_output_volume;
    next_right_output_volume = right_output_volume;
    next_serial_port_format = serial_port_format;
    next_master_clock_ratio = master_clock_ratio;
    wr_left_vol = 1'b0;
    wr_right_vol = 1'b0;
    if (reg_write_in) begin
      case (reg_addr_in)
        acr_pkg::ADDR_ADC_CONTROL: begin
          next_adc_control = masked(adc_control, reg_wdata_in, acr_pkg::ADC_WMASK);
        end
        acr_pkg::ADDR_DAC_CONTROL: begin
          next_dac_control = masked(dac_control, reg_wdata_in, acr_pkg::DAC_WMASK);
        end
        acr_pkg::ADDR_LEFT_OUTPUT_VOLUME: begin
          next_left_output_volume = masked(left_output_volume, reg_wdata_in,
                                           acr_pkg::VOL_WMASK);
          wr_left_vol = 1'b1;
        end
        acr_pkg::ADDR_RIGHT_OUTPUT_VOLUME: begin
          next_right_output_volume = masked(right_output_volume, reg_wdata_in,
                                            acr_pkg::VOL_WMASK);
          wr_right_vol = 1'b1;
        end
        acr_pkg::ADDR_SERIAL_PORT_FORMAT: begin
          next_serial_port_format = masked(serial_port_format, reg_wdata_in,
                                           acr_pkg::SPF_WMASK);
        end
        acr_pkg::ADDR_MASTER_CLOCK_RATIO: begin
          next_master_clock_ratio = masked(master_clock_ratio, reg_wdata_in,
                                           acr_pkg::MCK_WMASK);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      adc_control <= acr_pkg::REG_RESET;
      dac_control <= acr_pkg::REG_RESET;
      left_output_volume <= acr_pkg::REG_RESET;
      right_output_volume <= acr_pkg::REG_RESET;
      serial_port_format <= acr_pkg::REG_RESET;
      master_clock_ratio <= acr_pkg::REG_RESET;
    end else begin
      adc_control <= next_adc_control;
      dac_control <= next_dac_control;
      left_output_volume <= next_left_output_volume;
      right_output_volume <= next_right_output_volume;
      serial_port_format <= next_serial_port_format;
      master_clock_ratio <= next_master_clock_ratio;
    end
  end

  // configuration outputs are the register bits themselves
  always_comb begin
    cfg_out.adc_sleep = adc_control[acr_pkg::ADC_SLEEP_BIT];
    cfg_out.highpass_bypass_right = adc_control[acr_pkg::HP_BYPASS_R_BIT];
    cfg_out.highpass_bypass_left = adc_control[acr_pkg::HP_BYPASS_L_BIT];
    cfg_out.adc_silence_right = adc_control[acr_pkg::ADC_SILENCE_R_BIT];
    cfg_out.adc_silence_left = adc_control[acr_pkg::ADC_SILENCE_L_BIT];
    cfg_out.treble_cut_filter_select =
      acr_pkg::acr_deemph_t'(serial_port_format[acr_pkg::TREBLE_CUT_LSB +: 2]);
    cfg_out.bit_clock_edge_select = serial_port_format[acr_pkg::EDGE_SELECT_BIT];
    cfg_out.serial_output_layout =
      acr_pkg::acr_fmt_t'(serial_port_format[acr_pkg::OUT_LAYOUT_LSB +: 2]);
    cfg_out.serial_input_layout =
      acr_pkg::acr_fmt_t'(serial_port_format[acr_pkg::IN_LAYOUT_LSB +: 2]);
    // only meaningful in master mode; slave mode logic ignores it
    cfg_out.master_clock_ratio_select =
      acr_pkg::acr_mclk_t'(master_clock_ratio[acr_pkg::MCLK_RATIO_LSB +: 2]);
  end

  // ---- ramp step pacing from frame clock periods
  logic [5:0] frame_cnt, next_frame_cnt;
  logic step_tick;

  always_comb begin
    step_tick = 1'b0;
    next_frame_cnt = frame_cnt;
    if (frame_rise) begin
      if (frame_cnt >= step_div(dac_control[acr_pkg::RAMP_RATE_LSB +: 2]) - 6'd1) begin
        next_frame_cnt = '0;
        step_tick = 1'b1;
      end else begin
        next_frame_cnt = frame_cnt + 6'd1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      frame_cnt <= '0;
    end else begin
      frame_cnt <= next_frame_cnt;
    end
  end

  // ---- offset trim and clock fault
  logic [CAL_W-1:0] cal_cnt, next_cal_cnt;
  logic next_trim_running;
  logic [FLT_W-1:0] flt_cnt, next_flt_cnt;
  logic next_fault;

  always_comb begin
    next_cal_cnt = cal_cnt;
    next_trim_running = offset_trim_running_out;
    if (rstl_rise && adc_control[acr_pkg::CAL_ON_RESET_BIT]) begin
      next_cal_cnt = '0;
      next_trim_running = 1'b1;
    end else if (offset_trim_running_out) begin
      if (cal_cnt == CAL_W'(CAL_CYCLES - 1)) begin
        next_trim_running = 1'b0;
      end else begin
        next_cal_cnt = cal_cnt + 1'b1;
      end
    end
    // a frame clock that stops for too long counts as a clocking error
    if (frame_edge) begin
      next_flt_cnt = '0;
    end else if (flt_cnt != FLT_W'(CLK_FAULT_CYCLES)) begin
      next_flt_cnt = flt_cnt + 1'b1;
    end else begin
      next_flt_cnt = flt_cnt;
    end
    next_fault = (next_flt_cnt == FLT_W'(CLK_FAULT_CYCLES));
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cal_cnt <= '0;
      offset_trim_running_out <= 1'b1;
      flt_cnt <= '0;
      clock_fault_flag_out <= 1'b0;
    end else begin
      cal_cnt <= next_cal_cnt;
      offset_trim_running_out <= next_trim_running;
      flt_cnt <= next_flt_cnt;
      clock_fault_flag_out <= next_fault;
    end
  end

  // ---- dac channels
  logic pending_left, pending_right;

  acr_chan u_left (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .vol_code_in(left_output_volume),
    .vol_write_in(wr_left_vol),
    .force_mute_in(dac_control[acr_pkg::DAC_SILENCE_L_BIT]),
    .zero_run_enable_in(dac_control[acr_pkg::ZERO_RUN_EN_BIT]),
    .zero_cross_mode_in(dac_control[acr_pkg::ZERO_CROSS_MODE_BIT]),
    .step_tick_in(step_tick),
    .frame_tick_in(frame_rise),
    .samp_in(left_samp_in),
    .level_out(left_level_out),
    .pending_out(pending_left)
  );

  acr_chan u_right (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .vol_code_in(right_output_volume),
    .vol_write_in(wr_right_vol),
    .force_mute_in(dac_control[acr_pkg::DAC_SILENCE_R_BIT]),
    .zero_run_enable_in(dac_control[acr_pkg::ZERO_RUN_EN_BIT]),
    .zero_cross_mode_in(dac_control[acr_pkg::ZERO_CROSS_MODE_BIT]),
    .step_tick_in(step_tick),
    .frame_tick_in(frame_rise),
    .samp_in(right_samp_in),
    .level_out(right_level_out),
    .pending_out(pending_right)
  );

  // ---- peak meters and read path
  logic [2:0] peak_left, peak_right, next_peak_left, next_peak_right;
  logic [7:0] next_rdata;
  logic next_rvalid, read_ok, status_read;

  always_comb begin
    // spi mode has no readback: the request is dropped without an answer
    read_ok = reg_read_in && !spi_mode;
    status_read = read_ok && (reg_addr_in == acr_pkg::ADDR_CONVERTER_STATUS);
    next_peak_left = status_read ? 3'h0 : peak_left;
    next_peak_right = status_read ? 3'h0 : peak_right;
    // a peak arriving with the clearing read is kept
    if (peak_valid_in) begin
      next_peak_left = peak_max(next_peak_left, peak_meter_left_in);
      next_peak_right = peak_max(next_peak_right, peak_meter_right_in);
    end
    next_rvalid = read_ok;
    next_rdata = 8'h00;
    if (read_ok) begin
      case (reg_addr_in)
        acr_pkg::ADDR_ADC_CONTROL: begin
          next_rdata = {adc_control[7:2], offset_trim_running_out, clock_fault_flag_out};
        end
        acr_pkg::ADDR_DAC_CONTROL: next_rdata = dac_control;
        acr_pkg::ADDR_LEFT_OUTPUT_VOLUME: next_rdata = left_output_volume;
        acr_pkg::ADDR_RIGHT_OUTPUT_VOLUME: next_rdata = right_output_volume;
        acr_pkg::ADDR_SERIAL_PORT_FORMAT: next_rdata = serial_port_format;
        acr_pkg::ADDR_CONVERTER_STATUS: begin
          next_rdata = {pending_right, pending_left, peak_right, peak_left};
        end
        acr_pkg::ADDR_MASTER_CLOCK_RATIO: next_rdata = master_clock_ratio;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      peak_left <= 3'h0;
      peak_right <= 3'h0;
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      peak_left <= next_peak_left;
      peak_right <= next_peak_right;
      reg_rdata_out <= next_rdata;
      reg_rvalid_out <= next_rvalid;
    end
  end
endmodule

// ### tb/acr_regs_chk.sv
// acr_regs_chk: port-level assertions for the codec register bank.
// assumes it is bound onto acr_regs and sees that module's ports only.
`timescale 1ns/10ps
module acr_regs_chk #(
  parameter longint CAL_CYCLES = 200,
  parameter int CLK_FAULT_CYCLES = 64
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic spi_mode_in,
  input wire logic frame_clock_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire acr_pkg::acr_cfg_t cfg_out,
  input wire logic [7:0] left_level_out,
  input wire logic offset_trim_running_out,
  input wire logic clock_fault_flag_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic fc_q;
  int stall;
  int next_stall;
  // cycles since the frame clock pin last moved, saturating
  always_comb begin
    next_stall = (frame_clock_in != fc_q) ? 0 : ((stall < 1000) ? stall + 1 : stall);
  end
  always_ff @(posedge clk_sys_in) begin
    fc_q <= frame_clock_in;
    stall <= next_stall;
  end
  // the mode pin has settled through its synchroniser before the read
  sequence spi_read_held;
    spi_mode_in [*4] ##0 reg_read_in;
  endsequence
  rvalid_cause_a: assert property (reg_rvalid_out |-> $past(reg_read_in))
    else $error("read answer without a read strobe");
  spi_refuse_a: assert property (spi_read_held |=> !reg_rvalid_out)
    else $error("read answered in write-only mode");
  rdata_idle_a: assert property (!reg_rvalid_out |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside an answer");
  adc_write_a: assert property (reg_write_in && reg_addr_in == acr_pkg::ADDR_ADC_CONTROL |=>
    {cfg_out.adc_sleep, cfg_out.highpass_bypass_right, cfg_out.highpass_bypass_left,
     cfg_out.adc_silence_right, cfg_out.adc_silence_left} == $past(reg_wdata_in[7:3]))
    else $error("adc control bits not taken from write");
  fmt_write_a: assert property (reg_write_in && reg_addr_in == acr_pkg::ADDR_SERIAL_PORT_FORMAT |=>
    {cfg_out.treble_cut_filter_select, cfg_out.bit_clock_edge_select, cfg_out.serial_output_layout,
     cfg_out.serial_input_layout} == $past(reg_wdata_in[6:0]))
    else $error("serial format bits not taken from write");
  mck_write_a: assert property (reg_write_in && reg_addr_in == acr_pkg::ADDR_MASTER_CLOCK_RATIO |=>
    cfg_out.master_clock_ratio_select == $past(reg_wdata_in[1:0]))
    else $error("clock ratio not taken from write");
  trim_start_a: assert property ($fell(srst_in) |-> offset_trim_running_out [*3])
    else $error("offset trim not running after reset");
  level_cap_a: assert property (left_level_out <= acr_pkg::VOL_MUTE_CODE)
    else $error("left level beyond the mute code");
  fault_raise_a: assert property (stall == CLK_FAULT_CYCLES + 6 |-> clock_fault_flag_out)
    else $error("stalled frame clock not flagged");
endmodule
bind acr_regs acr_regs_chk #(.CAL_CYCLES(CAL_CYCLES), .CLK_FAULT_CYCLES(CLK_FAULT_CYCLES))
  acr_regs_chk_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .spi_mode_in(spi_mode_in),
  .frame_clock_in(frame_clock_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .cfg_out(cfg_out), .left_level_out(left_level_out),
  .offset_trim_running_out(offset_trim_running_out),
  .clock_fault_flag_out(clock_fault_flag_out));

// ### tb/acr_host_model.sv
// acr_host_model: far-side source of the frame clock and dac samples.
// assumes a free-running 320 ns frame clock, unrelated in phase to clk_sys_in.
`timescale 1ns/10ps
module acr_host_model (
  input wire logic clk_sys_in,
  input wire logic run_in,
  input wire logic static_in,
  output logic frame_clock_out,
  output acr_pkg::acr_samp_t left_samp_out,
  output acr_pkg::acr_samp_t right_samp_out
);
  logic fc_q = 1'b0;
  logic neg = 1'b0;
  initial begin
    frame_clock_out = 1'b0;
    #7;
    forever begin
      // only the frame clock is modelled; a right-justified slave source also owes 64 Fs
      #160;
      // stops only when a scenario asks, to provoke the clock fault flag
      if (run_in) frame_clock_out = ~frame_clock_out;
    end
  end
  // one sample per frame; sign alternates so zero crossings come often
  // a static run is -1: it never crosses zero, so zero-cross mode has to time out
  always @(negedge clk_sys_in) begin
    fc_q <= frame_clock_out;
    neg <= neg ^ (frame_clock_out & ~fc_q);
    left_samp_out.valid <= frame_clock_out & ~fc_q;
    left_samp_out.data <= static_in ? 24'hffffff : (neg ? 24'hfff000 : 24'h001000);
  end
  assign right_samp_out = left_samp_out;
endmodule

// ### tb/tb_acr_regs.sv
// tb_acr_regs: self-checking bench for the codec register bank.
// assumes acr_host_model supplies frame clock and samples; trim shortened to 200 cycles.
`timescale 1ns/10ps
module tb_acr_regs;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic rst_line_n = 1'b1;
  logic spi = 1'b0;
  logic run = 1'b1;
  logic stat = 1'b0;
  logic pk_v = 1'b0;
  logic [2:0] pk_l = 3'h0;
  logic [2:0] pk_r = 3'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic fc;
  acr_pkg::acr_samp_t ls;
  acr_pkg::acr_samp_t rs;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] ll;
  logic [7:0] rl;
  logic trim;
  logic fault;
  logic [7:0] d;
  int err_count = 0;
  int compares = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  acr_regs #(.CAL_CYCLES(200), .CLK_FAULT_CYCLES(64)) acr_regs_inst (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .reset_line_n_in(rst_line_n),
    .spi_mode_in(spi), .frame_clock_in(fc), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_write_in(wr_s), .reg_read_in(rd_s), .left_samp_in(ls), .right_samp_in(rs),
    .peak_meter_left_in(pk_l), .peak_meter_right_in(pk_r), .peak_valid_in(pk_v),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .cfg_out(), .left_level_out(ll),
    .right_level_out(rl), .offset_trim_running_out(trim), .clock_fault_flag_out(fault));
  acr_host_model acr_host_model_inst (.clk_sys_in(clk_sys_in), .run_in(run),
    .static_in(stat), .frame_clock_out(fc), .left_samp_out(ls), .right_samp_out(rs));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys_in);
    addr = a;
    wd = v;
    wr_s = 1'b1;
    @(negedge clk_sys_in);
    wr_s = 1'b0;
  endtask
  // 8'hee stands for no answer at all
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys_in);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk_sys_in);
    rd_s = 1'b0;
    v = (rvalid === 1'b1) ? rdata : 8'hee;
  endtask
  task automatic wait_lvl(input logic r, input logic [7:0] e, input int lim);
    int c;
    c = 0;
    while ((r ? rl : ll) !== e && c < lim) begin
      @(negedge clk_sys_in);
      c++;
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset;
    int c;
    rd(8'h01, d);
    check(d, 8'h02);
    c = 0;
    while (trim === 1'b1 && c < 400) begin
      @(negedge clk_sys_in);
      c++;
    end
    check(16'(c > 150 && c < 220), 16'h0001);
    for (int a = 0; a < 9; a++) begin
      rd(8'(a), d);
      check(d, 8'h00);
    end
    $display("test reset done");
  endtask
  task automatic t_rw;
    logic [7:0] ta [6] = '{8'h01, 8'h02, 8'h05, 8'h07, 8'h06, 8'h09};
    logic [7:0] tw [6] = '{8'hff, 8'h84, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] te [6] = '{8'hfc, 8'h00, 8'h7f, 8'h03, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      wr(ta[i], tw[i]);
      rd(ta[i], d);
      check(d, te[i]);
      wr(ta[i], 8'h00);
    end
    $display("test access done");
  endtask
  task automatic t_spi;
    spi = 1'b1;
    tick(4);
    rd(8'h05, d);
    check(d, 8'hee);
    wr(8'h05, 8'h12);
    spi = 1'b0;
    tick(4);
    rd(8'h05, d);
    check(d, 8'h12);
    wr(8'h05, 8'h00);
    $display("test spi done");
  endtask
  // interval between two ramp steps is exact because the frame clock is periodic
  task automatic t_rate;
    int n [4] = '{8, 4, 16, 32};
    int c;
    logic [7:0] l;
    for (int r = 0; r < 4; r++) begin
      wr(8'h02, 8'(r));
      wr(8'h03, ll + 8'h03);
      rd(8'h06, d);
      check(d[6], 1'b1);
      for (int k = 0; k < 2; k++) begin
        l = ll;
        c = 0;
        while (ll === l && c < 600) begin
          @(negedge clk_sys_in);
          c++;
        end
      end
      check(16'(c), 16'(8 * n[r]));
      wait_lvl(1'b0, 8'(3 * r + 3), 600);
      rd(8'h06, d);
      check(d, 8'h00);
    end
    $display("test ramp done");
  endtask
  task automatic t_mute;
    wr(8'h02, 8'h08);
    wr(8'h03, 8'he5);
    wait_lvl(1'b0, 8'he4, 40);
    check(ll, 8'he4);
    wr(8'h02, 8'h28);
    wait_lvl(1'b1, 8'he4, 40);
    check(rl, 8'he4);
    wr(8'h03, 8'h00);
    wr(8'h02, 8'h08);
    wait_lvl(1'b1, 8'h00, 40);
    wait_lvl(1'b0, 8'h00, 40);
    check({ll, rl}, 16'h0000);
    wr(8'h02, 8'h48);
    stat = 1'b1;
    tick(8 * 500);
    check({ll, rl}, 16'h0000);
    tick(8 * 20);
    check({ll, rl}, 16'h0000);
    tick(8 * 520);
    check({ll, rl}, 16'he4e4);
    stat = 1'b0;
    tick(32);
    check({ll, rl}, 16'h0000);
    wr(8'h02, 8'h00);
    $display("test mute done");
  endtask
  task automatic t_peak;
    pk_l = 3'h3;
    pk_r = 3'h5;
    pk_v = 1'b1;
    tick(1);
    pk_l = 3'h2;
    pk_r = 3'h1;
    tick(1);
    pk_v = 1'b0;
    rd(8'h06, d);
    check(d, 8'h2b);
    rd(8'h06, d);
    check(d, 8'h00);
    $display("test peak done");
  endtask
  task automatic t_trim_fault;
    wr(8'h01, 8'h04);
    rst_line_n = 1'b0;
    tick(4);
    rst_line_n = 1'b1;
    tick(10);
    rd(8'h01, d);
    check(d, 8'h06);
    tick(220);
    rd(8'h01, d);
    check(d, 8'h04);
    wr(8'h01, 8'h00);
    run = 1'b0;
    tick(100);
    rd(8'h01, d);
    check({fault, d}, 9'h101);
    run = 1'b1;
    tick(40);
    rd(8'h01, d);
    check(d, 8'h00);
    $display("test trim and fault done");
  endtask
  initial begin
    tick(3);
    srst_in = 1'b0;
    t_reset();
    t_rw();
    t_spi();
    t_rate();
    t_mute();
    t_peak();
    t_trim_fault();
    print_verdict();
  end
  initial begin
    #(40 * 40000);
    err_count++;
    print_verdict();
  end
endmodule
